// *** led_ctrl_pkg.sv ***
package led_ctrl_pkg;

  // Board clock rate and common blink period
  localparam int unsigned ClkHz = 25000000;
  localparam int unsigned BlinkPeriodMs = 1000;
  localparam int unsigned BlinkCycles = ClkHz / 1000 * BlinkPeriodMs;
  // One tenth of the blink period is the duty step
  localparam int unsigned DutyTenthCycles = BlinkCycles / 10;
  localparam logic [3:0] DutyShort = 4'h1;
  localparam logic [3:0] DutyLong = 4'h9;
  localparam logic [3:0] DutySteps = 4'hA;
  // Fail-safe amber blink uses half duty
  localparam logic [3:0] DutyHalf = 4'h5;

  // Status bit positions
  localparam int unsigned StRemoveReady = 0;
  localparam int unsigned StHealthFault = 1;
  localparam int unsigned StUpdateFreeze = 2;
  localparam int unsigned StatusWidth = 3;

  typedef enum logic [2:0] {
    UnitInactive = 3'b000,
    UnitActReq = 3'b001,
    UnitActivating = 3'b010,
    UnitActive = 3'b011,
    UnitDeactReq = 3'b100,
    UnitDeactivating = 3'b101
  } unit_state_t;

  typedef enum logic [1:0] {
    CtrlReset = 2'b00,
    CtrlStarting = 2'b01,
    CtrlRunning = 2'b10
  } ctrl_phase_t;

  typedef struct packed {
    unit_state_t unitState;
    logic outOfServiceState;
    logic healthOverride;
    logic healthOverrideGreen;
    logic healthOverrideAmber;
    logic userGreen;
    logic userAmber;
  } mgmt_cmd_t;

  typedef struct packed {
    logic removalStatusLamp;
    logic serviceFaultLamp;
    logic healthGreen;
    logic healthAmber;
    logic userGreen;
    logic userAmber;
  } lamps_t;

  localparam logic [2:0] RegStatus = 3'h0;
  localparam logic [2:0] RegMask = 3'h1;
  localparam logic [2:0] RegImage = 3'h2;

endpackage

// *** blade_status_led_controller.sv ***
// Functional notes
// - Hot-swap lamp steadily lit when safe to withdraw, dark in operation.
// - Hot-swap duty: inactive 100, activation request 90, active 0, deact 10.
// - Out-of-service lamp on while controller is in reset or starting.
// - After start-up out-of-service lamp follows controller command.
// - Outside the factory image, health lamp green when payload up, all sensors fine and no override commanded, off unpowered.
// - Outside the factory image, health lamp amber whenever any voltage or temperature sensor fails while payload power is good.
// - Health lamp blinks amber when running from factory fail-safe image.
// - Latch controller critical commands, hold them during firmware update.
// - Image choice is taken only at power-up; new image needs power cycle.
// - Jumper inserted selects the factory image.
// - User lamp green and amber driven only as the controller commands.
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module blade_status_led_controller
  import led_ctrl_pkg::*;
#(
  parameter int unsigned BlinkLen = BlinkCycles
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic ctrlInReset,
  input wire logic ctrlStartupDone,
  input wire logic fwUpdateActive,
  input wire logic cmdStrobe,
  input wire mgmt_cmd_t cmdIn,
  input wire logic payloadPowerGood,
  input wire logic [7:0] voltageFail,
  input wire logic [7:0] tempFail,
  input wire logic image_select_jumper,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdData,
  output lamps_t lamps,
  output unit_state_t heldUnitState,
  output logic factoryImage,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] periodCnt_reg;
  logic [3:0] dutyStep_reg;
  logic [31:0] tenthLen;
  assign tenthLen = 32'(BlinkLen / 10);

  function automatic logic dutyOn(input logic [3:0] step,
                                  input logic [3:0] duty);
    dutyOn = step < duty;
  endfunction

  // One counter for every blink keeps all patterns phase aligned
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      periodCnt_reg <= 32'h0;
      dutyStep_reg <= 4'h0;
    end else if (periodCnt_reg + 32'h1 >= tenthLen) begin
      periodCnt_reg <= 32'h0;
      dutyStep_reg <= (dutyStep_reg == DutySteps - 4'h1) ? 4'h0
                      : dutyStep_reg + 4'h1;
    end else begin
      periodCnt_reg <= periodCnt_reg + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Image choice caught once after power-up reset only
  logic imageTaken_reg;
  logic factory_reg;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      imageTaken_reg <= 1'b0;
      factory_reg <= 1'b0;
    end else if (!imageTaken_reg) begin
      imageTaken_reg <= 1'b1;
      factory_reg <= image_select_jumper;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  ctrl_phase_t phase_reg;
  always_ff @(posedge ref_clk) begin
    if (reset || ctrlInReset) begin
      phase_reg <= CtrlReset;
    end else begin
      case (phase_reg)
        CtrlReset: phase_reg <= CtrlStarting;
        CtrlStarting: begin
          if (ctrlStartupDone) begin
            phase_reg <= CtrlRunning;
          end
        end
        CtrlRunning: phase_reg <= CtrlRunning;
        default: phase_reg <= CtrlReset;
      endcase
    end
  end

  // Commands are frozen during firmware update so outputs never glitch
  mgmt_cmd_t cmd_reg;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cmd_reg <= '{unitState: UnitInactive, default: 1'b0};
    end else if (cmdStrobe && !fwUpdateActive) begin
      cmd_reg <= cmdIn;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic sensorFault;
  assign sensorFault = payloadPowerGood && ((|voltageFail) || (|tempFail));

  lamps_t lampNext;
  always_comb begin
    lampNext = '0;
    case (cmd_reg.unitState)
      UnitInactive: lampNext.removalStatusLamp = 1'b1;
      UnitActReq: lampNext.removalStatusLamp = dutyOn(dutyStep_reg, DutyLong);
      UnitActivating, UnitActive: lampNext.removalStatusLamp = 1'b0;
      UnitDeactReq, UnitDeactivating:
        lampNext.removalStatusLamp = dutyOn(dutyStep_reg, DutyShort);
      default: lampNext.removalStatusLamp = 1'b0;
    endcase
    if (phase_reg != CtrlRunning) begin
      lampNext.serviceFaultLamp = 1'b1;
    end else begin
      lampNext.serviceFaultLamp = cmd_reg.outOfServiceState;
    end
    if (factory_reg) begin
      lampNext.healthAmber = dutyOn(dutyStep_reg, DutyHalf);
    end else if (!payloadPowerGood) begin
      lampNext.healthGreen = 1'b0;
    end else if (sensorFault) begin
      lampNext.healthAmber = 1'b1;
    end else if (cmd_reg.healthOverride) begin
      lampNext.healthGreen = cmd_reg.healthOverrideGreen;
      lampNext.healthAmber = cmd_reg.healthOverrideAmber;
    end else begin
      lampNext.healthGreen = 1'b1;
    end
    lampNext.userGreen = cmd_reg.userGreen;
    lampNext.userAmber = cmd_reg.userAmber;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      lamps <= '{removalStatusLamp: 1'b1, serviceFaultLamp: 1'b1,
                 default: 1'b0};
      heldUnitState <= UnitInactive;
      factoryImage <= 1'b0;
    end else begin
      lamps <= lampNext;
      heldUnitState <= cmd_reg.unitState;
      factoryImage <= factory_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Events: unit ready for removal, sensor fault, update freeze began
  logic [StatusWidth-1:0] status_reg;
  logic [StatusWidth-1:0] mask_reg;
  logic [StatusWidth-1:0] events;
  logic removeSeen_reg;
  logic faultSeen_reg;
  logic updSeen_reg;

  // Held state resets to inactive, so the removal detector must start as seen
  // or every reset would raise a false removal-ready event
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      removeSeen_reg <= 1'b1;
      faultSeen_reg <= 1'b0;
      updSeen_reg <= 1'b0;
    end else begin
      removeSeen_reg <= cmd_reg.unitState == UnitInactive;
      faultSeen_reg <= sensorFault;
      updSeen_reg <= fwUpdateActive;
    end
  end

  always_comb begin
    events = '0;
    events[StRemoveReady] = (cmd_reg.unitState == UnitInactive)
                            && !removeSeen_reg;
    events[StHealthFault] = sensorFault && !faultSeen_reg;
    events[StUpdateFreeze] = fwUpdateActive && !updSeen_reg;
  end

  // A new event wins over a write-one clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      status_reg <= '0;
    end else if (regWrite && regAddr == RegStatus) begin
      status_reg <= (status_reg & ~regWrData[StatusWidth-1:0]) | events;
    end else begin
      status_reg <= status_reg | events;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mask_reg <= '0;
    end else if (regWrite && regAddr == RegMask) begin
      mask_reg <= regWrData[StatusWidth-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_reg & mask_reg);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      regRdData <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        RegStatus: regRdData <= 8'(status_reg);
        RegMask: regRdData <= 8'(mask_reg);
        RegImage: regRdData <= {7'h00, factory_reg};
        default: regRdData <= 8'h00;
      endcase
    end else begin
      regRdData <= 8'h00;
    end
  end

endmodule // blade_status_led_controller

`default_nettype wire

// *** mgmt_ctrl_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module mgmt_ctrl_model
  import led_ctrl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sendReq,
  input wire mgmt_cmd_t sendCmd,
  output var logic cmdStrobe = 1'b0,
  output var mgmt_cmd_t cmdIn = '0
);
  // One strobe per whole command
  always @(posedge ref_clk) begin
    cmdStrobe <= sendReq;
    // Idle lines wander so a stale command is never mistaken for a new one
    cmdIn <= sendReq ? sendCmd : mgmt_cmd_t'(~cmdIn);
  end
endmodule // mgmt_ctrl_model

`default_nettype wire

// *** blade_status_led_controller_sva.sv ***
`timescale 1ns/1ps
`default_nettype none

module led_ctrl_checker
  import led_ctrl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic ctrlInReset,
  input wire logic fwUpdateActive,
  input wire logic cmdStrobe,
  input wire mgmt_cmd_t cmdIn,
  input wire logic payloadPowerGood,
  input wire logic [7:0] voltageFail,
  input wire logic [7:0] tempFail,
  input wire logic image_select_jumper,
  input wire lamps_t lamps,
  input wire unit_state_t heldUnitState,
  input wire logic factoryImage
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////
  property p_oos; ctrlInReset |-> ##2 lamps.serviceFaultLamp; endproperty
  a_oos: assert property (p_oos) else $error("oos lamp off");
  property p_user;
    cmdStrobe && !fwUpdateActive ##1 !cmdStrobe
      |=> lamps.userGreen == $past(cmdIn.userGreen, 2);
  endproperty
  a_user: assert property (p_user) else $error("user lamp wrong");
  property p_freeze; fwUpdateActive [*3] |-> $stable(lamps.userAmber);
  endproperty
  a_freeze: assert property (p_freeze) else $error("held lamp moved");
  property p_fault;
    (payloadPowerGood && (|voltageFail || |tempFail) && !factoryImage) [*3]
      |=> lamps.healthAmber && !lamps.healthGreen;
  endproperty
  a_fault: assert property (p_fault) else $error("no amber on fault");
  property p_off; (!payloadPowerGood && !factoryImage) [*3]
    |-> !lamps.healthGreen && !lamps.healthAmber; endproperty
  a_off: assert property (p_off) else $error("health lamp lit");
  property p_image; $past(reset, 3) == 1'b0 |-> $stable(factoryImage);
  endproperty
  a_image: assert property (p_image) else $error("image changed");
  property p_jumper;
    $fell(reset) |-> ##2 factoryImage == image_select_jumper;
  endproperty
  a_jumper: assert property (p_jumper) else $error("bad image");
  property p_inact; (heldUnitState == UnitInactive) [*2]
    |-> lamps.removalStatusLamp; endproperty
  a_inact: assert property (p_inact) else $error("removal dark");
  property p_active; (heldUnitState == UnitActive) [*2]
    |-> !lamps.removalStatusLamp; endproperty
  a_active: assert property (p_active) else $error("removal lit");
endmodule // led_ctrl_checker

bind blade_status_led_controller led_ctrl_checker chk (.ref_clk, .reset,
  .ctrlInReset, .fwUpdateActive, .cmdStrobe, .cmdIn, .payloadPowerGood,
  .voltageFail, .tempFail, .image_select_jumper, .lamps, .heldUnitState,
  .factoryImage);

`default_nettype wire

// *** tb_blade_status_led_controller.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_blade_status_led_controller;
  import led_ctrl_pkg::*;
  localparam int BL = 100;
  logic ref_clk = 0, reset = 1, ctrlInReset = 1, ctrlStartupDone = 0;
  logic fwUpdateActive = 0, sendReq = 0, cmdStrobe, payloadPowerGood = 0;
  logic image_select_jumper = 0, regWrite = 0, regRead = 0, irq;
  logic [7:0] voltageFail = 0, tempFail = 0, regWrData = 0, regRdData, d;
  logic [2:0] regAddr = 0;
  logic [31:0] n;
  mgmt_cmd_t sendCmd = '0, cmdIn, c = '0;
  lamps_t lamps;
  unit_state_t heldUnitState;
  logic factoryImage;
  int errCount = 0, checkCount = 0;
  always #20 ref_clk = ~ref_clk;
  mgmt_ctrl_model partner (.ref_clk, .sendReq, .sendCmd, .cmdStrobe, .cmdIn);
  blade_status_led_controller #(.BlinkLen(BL)) DUT (.ref_clk, .reset,
    .ctrlInReset, .ctrlStartupDone, .fwUpdateActive, .cmdStrobe, .cmdIn,
    .payloadPowerGood, .voltageFail, .tempFail, .image_select_jumper,
    .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .lamps,
    .heldUnitState, .factoryImage, .irq);
  ////////////////////////////////////////////////////////////////////////////
  task check(input string nm, input logic [31:0] s, input logic [31:0] e);
    checkCount++;
    if (s !== e) begin
      errCount++;
      $display("unexpected %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  task completeRun;
    $display("checks %0d mismatches %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task send;
    sendCmd <= c; sendReq <= 1; @(posedge ref_clk); sendReq <= 0;
    repeat (5) @(posedge ref_clk);
  endtask
  task wr(input logic [2:0] a, input logic [7:0] v);
    regAddr <= a; regWrData <= v; regWrite <= 1;
    @(posedge ref_clk); regWrite <= 0; @(posedge ref_clk);
  endtask
  task rd(input logic [2:0] a);
    regAddr <= a; regRead <= 1;
    @(posedge ref_clk); regRead <= 0; #1 d = regRdData; @(posedge ref_clk);
  endtask
  task count(input int b); // Lit cycles over one blink period
    n = 0;
    repeat (BL) begin @(negedge ref_clk); n += (lamps[b] === 1'b1); end
    @(posedge ref_clk);
  endtask
  task power_cycle;
    reset <= 1; repeat (5) @(posedge ref_clk); reset <= 0;
    repeat (4) @(posedge ref_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task lamp_cmds;
    #1 check("oos", lamps.serviceFaultLamp, 1);
    ctrlInReset <= 0; ctrlStartupDone <= 1; repeat (4) @(posedge ref_clk);
    c.outOfServiceState = 0; c.userGreen = 1; send;
    check("oos", lamps.serviceFaultLamp, 0);
    check("user", lamps.userGreen, 1);
    fwUpdateActive <= 1; c.userAmber = 1; send; // Refused while updating
    check("freeze", lamps.userAmber, 0);
    fwUpdateActive <= 0; payloadPowerGood <= 1; send;
    check("green", lamps.healthGreen, 1);
    voltageFail <= 8'h80; repeat (4) @(posedge ref_clk);
    check("amber", lamps.healthAmber, 1);
  endtask
  task duty_table;
    unit_state_t st[6] = '{UnitActive, UnitInactive, UnitActReq,
      UnitActivating, UnitDeactReq, UnitDeactivating};
    int tenths[6] = '{0, 10, 9, 0, 1, 1};
    for (int i = 0; i < 6; i++) begin
      c.unitState = st[i]; send; count(5);
      check("held", heldUnitState, st[i]);
      check("duty", n, tenths[i] * BL / 10);
    end
  endtask
  task irq_path;
    rd(3'h0); check("status", d, 8'h07);
    wr(3'h1, 8'h01); @(negedge ref_clk); check("irq", irq, 1);
    @(posedge ref_clk);
    wr(3'h0, 8'h07); rd(3'h0); check("clear", d, 8'h00);
    check("irq", irq, 0);
    rd(3'h7); check("unmapped", d, 8'h00);
  endtask
  task image_sel;
    image_select_jumper <= 1; power_cycle;
    rd(3'h2); check("image", d, 8'h01);
    check("imgpin", factoryImage, 1);
    count(2); check("blink", n, BL / 2);
    image_select_jumper <= 0; repeat (4) @(posedge ref_clk);
    rd(3'h2); check("image", d, 8'h01);
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    reset <= 0; repeat (4) @(posedge ref_clk);
    lamp_cmds; duty_table; irq_path; image_sel;
    completeRun;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    errCount++;
    completeRun;
  end
endmodule // tb_blade_status_led_controller

`default_nettype wire
